// [hdl/bfsp_ctrl.sv]
// Purpose: address mapping and command sequencing for boot-loader self-programming of program flash
// Assumes: inputs synchronous to CLK_SYS; core obeys polling, interrupt and sequence duties
// Notes: flash array itself is outside; this block issues erase/write/fill and gates fetches
//
// Notes on behaviour
// - two boot-size fuses pick 256..2048-word boot section; its start is boot reset address
// - words 0x3800..0x3FFF form no-read-while-write section, the rest read-while-write
// - program counter is 14 bits, flash holds 16K words
// - page has 64 words, low six counter bits pick the word
// - erase and write take page from pointer bits 14..7
// - pointer bits 6..1 pick buffer word; software zeroes them for page write
// - pointer bit 15 ignored for all store and load operations
// - pointer bit 0 zero for stores; byte select for loads
// - during erase or write only no-read-while-write fetches allowed
// - busy flag stays until re-enable command; software polls the command enable bit clear
// - store must follow within four cycles, otherwise command bits clear
// - busy flag set while section occupied by erase or write
// - eeprom write in progress blocks every flash programming command
`timescale 1ns/10ps
`include "bfsp_map.svh"
module bfsp_ctrl #(
  parameter int PROG_CYCLES = `BFSP_PROG_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic BOOT_SIZE_FUSE_HI,
  input wire logic BOOT_SIZE_FUSE_LO,
  input wire logic EEPROM_WRITE_IN_PROGRESS_FLAG,
  input wire logic [13:0] FETCH_ADDR,
  input wire logic FETCH_REQ,
  output logic FETCH_STALL,
  output logic [13:0] BOOT_RESET_ADDR,
  output logic FLASH_ERASE,
  output logic FLASH_WRITE,
  output logic FLASH_FILL,
  output logic [7:0] FLASH_PAGE,
  output logic [5:0] FLASH_WORD,
  output logic [15:0] FLASH_DATA,
  output logic LOAD_HIGH_BYTE,
  output logic IRQ
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bfsp_pkg::bfsp_state_t state_r, state_nxt;
  logic [4:0] cmd_r, cmd_nxt;
  logic busy_flag_r, busy_flag_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic [15:0] data_r, data_nxt;
  logic [2:0] win_r, win_nxt;
  logic [22:0] prog_cnt_r, prog_cnt_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic stall_r, stall_nxt;
  logic [13:0] boot_r, boot_nxt;
  bfsp_pkg::bfsp_op_t op_r, op_nxt;
  logic load_hi_r, load_hi_nxt;
  logic irq_r, irq_nxt;
  bfsp_pkg::bfsp_ptr_t ptr_map;
  logic [2:0] ev;
  logic store_hit, in_no_read_while_write_section, prog_active;
  // ------------------------------------------------------------
  // address mapping
  // ------------------------------------------------------------
  always_comb begin
    ptr_map.page = ptr_r[14:7];
    ptr_map.word = ptr_r[6:1];
    ptr_map.byte_sel = ptr_r[0];
    in_no_read_while_write_section = (FETCH_ADDR >= `BFSP_NO_READ_WHILE_WRITE_SECTION_START);
    store_hit = REG_WR && (REG_ADDR == `BFSP_ADDR_STORE);
    prog_active = (state_r == bfsp_pkg::BFSP_BUSY);
    case ({BOOT_SIZE_FUSE_HI, BOOT_SIZE_FUSE_LO})
      2'b11: boot_nxt = `BFSP_BOOT_256;
      2'b10: boot_nxt = `BFSP_BOOT_512;
      2'b01: boot_nxt = `BFSP_BOOT_1K;
      default: boot_nxt = `BFSP_BOOT_2K;
    endcase
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    busy_flag_nxt = busy_flag_r;
    ptr_nxt = ptr_r;
    data_nxt = data_r;
    win_nxt = win_r;
    prog_cnt_nxt = prog_cnt_r;
    op_nxt = op_r;
    op_nxt.fill = 1'b0;
    load_hi_nxt = load_hi_r;
    ev = 3'h0;
    if (REG_WR && REG_ADDR == `BFSP_ADDR_PTR) begin
      ptr_nxt = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `BFSP_ADDR_DATA) begin
      data_nxt = REG_WDATA;
    end
    if (REG_RD && REG_ADDR == `BFSP_ADDR_LOAD) begin
      load_hi_nxt = ptr_map.byte_sel;
    end
    case (state_r)
      bfsp_pkg::BFSP_IDLE: begin
        if (REG_WR && REG_ADDR == `BFSP_ADDR_CTRL && REG_WDATA[`BFSP_CTRL_CMD_EN]) begin
          if (EEPROM_WRITE_IN_PROGRESS_FLAG) begin
            ev[`BFSP_IRQ_REFUSED] = 1'b1;
          end else begin
            cmd_nxt = REG_WDATA[4:0];
            win_nxt = `BFSP_STORE_WINDOW;
            state_nxt = bfsp_pkg::BFSP_ARMED;
          end
        end
      end
      bfsp_pkg::BFSP_ARMED: begin
        if (store_hit && !ptr_r[0]) begin
          ev[`BFSP_IRQ_DONE] = 1'b1;
          state_nxt = bfsp_pkg::BFSP_IDLE;
          cmd_nxt = 5'h00;
          if (cmd_r[`BFSP_CTRL_ERASE] || cmd_r[`BFSP_CTRL_WRITE]) begin
            op_nxt.erase = cmd_r[`BFSP_CTRL_ERASE];
            op_nxt.write = cmd_r[`BFSP_CTRL_WRITE];
            op_nxt.page = ptr_map.page;
            op_nxt.word = ptr_map.word;
            busy_flag_nxt = 1'b1;
            prog_cnt_nxt = 23'(PROG_CYCLES - 1);
            cmd_nxt = cmd_r;
            state_nxt = bfsp_pkg::BFSP_BUSY;
            ev[`BFSP_IRQ_DONE] = 1'b0;
          end else if (cmd_r[`BFSP_CTRL_REEN]) begin
            busy_flag_nxt = 1'b0;
          end else begin
            op_nxt.fill = 1'b1;
            op_nxt.word = ptr_map.word;
            op_nxt.data = data_r;
          end
        end else if (win_r == 3'h1) begin
          cmd_nxt = 5'h00;
          ev[`BFSP_IRQ_EXPIRED] = 1'b1;
          state_nxt = bfsp_pkg::BFSP_IDLE;
        end else begin
          win_nxt = win_r - 3'h1;
        end
      end
      bfsp_pkg::BFSP_BUSY: begin
        if (prog_cnt_r == 23'h0) begin
          op_nxt.erase = 1'b0;
          op_nxt.write = 1'b0;
          cmd_nxt = 5'h00;
          ev[`BFSP_IRQ_DONE] = 1'b1;
          state_nxt = bfsp_pkg::BFSP_IDLE;
        end else begin
          prog_cnt_nxt = prog_cnt_r - 23'h1;
        end
      end
      default: state_nxt = bfsp_pkg::BFSP_IDLE;
    endcase
  end
  // ------------------------------------------------------------
  // registers, interrupts and read port
  // ------------------------------------------------------------
  always_comb begin
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    if (REG_WR && REG_ADDR == `BFSP_ADDR_IRQ_MASK) begin
      irq_mask_nxt = REG_WDATA[2:0];
    end
    if (REG_WR && REG_ADDR == `BFSP_ADDR_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~REG_WDATA[2:0];
    end
    // set after clear: an event in the clearing cycle is not lost
    irq_stat_nxt = irq_stat_nxt | ev;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    // look ahead so the first programming cycle already stalls
    stall_nxt = FETCH_REQ && !in_no_read_while_write_section && (prog_active || state_nxt == bfsp_pkg::BFSP_BUSY);
    rdata_nxt = 16'h0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `BFSP_ADDR_CTRL: rdata_nxt = {9'h000, busy_flag_r, 1'b0, cmd_r};
        `BFSP_ADDR_PTR: rdata_nxt = ptr_r;
        `BFSP_ADDR_DATA: rdata_nxt = data_r;
        `BFSP_ADDR_IRQ_STAT: rdata_nxt = {13'h0000, irq_stat_r};
        `BFSP_ADDR_IRQ_MASK: rdata_nxt = {13'h0000, irq_mask_r};
        `BFSP_ADDR_LOAD: rdata_nxt = {2'h0, ptr_r[14:1]};
        `BFSP_ADDR_BOUNDS: rdata_nxt = {2'h0, boot_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_r <= bfsp_pkg::BFSP_IDLE;
      cmd_r <= 5'h00;
      busy_flag_r <= 1'b0;
      ptr_r <= 16'h0000;
      data_r <= 16'h0000;
      win_r <= 3'h0;
      prog_cnt_r <= 23'h0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      rdata_r <= 16'h0000;
      stall_r <= 1'b0;
      boot_r <= `BFSP_BOOT_2K;
      op_r <= '0;
      load_hi_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      busy_flag_r <= busy_flag_nxt;
      ptr_r <= ptr_nxt;
      data_r <= data_nxt;
      win_r <= win_nxt;
      prog_cnt_r <= prog_cnt_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r <= rdata_nxt;
      stall_r <= stall_nxt;
      boot_r <= boot_nxt;
      op_r <= op_nxt;
      load_hi_r <= load_hi_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign REG_RDATA = rdata_r;
  assign FETCH_STALL = stall_r;
  assign BOOT_RESET_ADDR = boot_r;
  assign FLASH_ERASE = op_r.erase;
  assign FLASH_WRITE = op_r.write;
  assign FLASH_FILL = op_r.fill;
  assign FLASH_PAGE = op_r.page;
  assign FLASH_WORD = op_r.word;
  assign FLASH_DATA = op_r.data;
  assign LOAD_HIGH_BYTE = load_hi_r;
  assign IRQ = irq_r;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_BOOT_START: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && BOOT_SIZE_FUSE_HI && BOOT_SIZE_FUSE_LO |=> BOOT_RESET_ADDR == 14'h3F00)
    else $error("boot start wrong");
  AST_NO_RWW_FETCH: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && FETCH_REQ && FETCH_ADDR < 14'h3800 && state_r == bfsp_pkg::BFSP_BUSY |=> FETCH_STALL)
    else $error("fetch not stalled");
  AST_NO_READ_WHILE_WRITE_SECTION_FREE: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && FETCH_REQ && FETCH_ADDR >= 14'h3800 |=> !FETCH_STALL)
    else $error("no_read_while_write_section fetch stalled");
  AST_WINDOW: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_IDLE && state_nxt == bfsp_pkg::BFSP_ARMED ##1 (CE && !store_hit) [*4]
    |=> cmd_r == 5'h00)
    else $error("command not expired");
  AST_EE_BLOCK: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_IDLE && EEPROM_WRITE_IN_PROGRESS_FLAG |=> state_r == bfsp_pkg::BFSP_IDLE)
    else $error("command taken during eeprom write");
  AST_BUSY_HELD: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    state_r == bfsp_pkg::BFSP_BUSY |-> busy_flag_r)
    else $error("busy flag low while programming");
  AST_PAGE_MAP: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_ARMED && store_hit && !ptr_r[0] && cmd_r[1] |=> FLASH_PAGE == $past(ptr_r[14:7]))
    else $error("page mapping wrong");
  AST_FILL_WORD: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_ARMED && store_hit && !ptr_r[0] && cmd_r[4:1] == 4'h0
    |=> FLASH_FILL && FLASH_WORD == $past(ptr_r[6:1]) && FLASH_DATA == $past(data_r))
    else $error("fill wrong");
  AST_REEN: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_ARMED && store_hit && !ptr_r[0] && cmd_r[4:1] == 4'h8 |=> !busy_flag_r)
    else $error("busy not cleared");
  AST_BOOT_2K: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && !BOOT_SIZE_FUSE_HI && !BOOT_SIZE_FUSE_LO |=> BOOT_RESET_ADDR == 14'h3800)
    else $error("largest boot start wrong");
  AST_WRITE_MAP: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_ARMED && store_hit && !ptr_r[0] && cmd_r[2] |=> FLASH_WRITE && FLASH_PAGE == $past(ptr_r[14:7]))
    else $error("write page mapping wrong");
  AST_FILL_PULSE: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && FLASH_FILL |=> !FLASH_FILL)
    else $error("fill longer than one cycle");
  AST_LOAD_MAP: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && REG_RD && REG_ADDR == `BFSP_ADDR_LOAD |=> REG_RDATA == {2'b00, $past(ptr_r[14:1])} && LOAD_HIGH_BYTE == $past(ptr_r[0]))
    else $error("load mapping wrong");
  AST_ODD_STORE: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_ARMED && store_hit && ptr_r[0]
    |=> state_r != bfsp_pkg::BFSP_BUSY && !FLASH_FILL)
    else $error("odd pointer store taken");
  AST_EE_REFUSED: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CE && state_r == bfsp_pkg::BFSP_IDLE && REG_WR && REG_ADDR == `BFSP_ADDR_CTRL && REG_WDATA[0] && EEPROM_WRITE_IN_PROGRESS_FLAG
    |=> irq_stat_r[`BFSP_IRQ_REFUSED])
    else $error("refusal not flagged");
  AST_FREEZE: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !CE |=> $stable(state_r) && $stable(ptr_r) && $stable(cmd_r))
    else $error("state moved while clock enable low");
  COV_ERASE: cover property (@(posedge CLK_SYS) FLASH_ERASE);
  COV_WRITE: cover property (@(posedge CLK_SYS) FLASH_WRITE);
  COV_FILL: cover property (@(posedge CLK_SYS) FLASH_FILL);
  COV_EXPIRE: cover property (@(posedge CLK_SYS) ev[`BFSP_IRQ_EXPIRED]);
  COV_REFUSED: cover property (@(posedge CLK_SYS) ev[`BFSP_IRQ_REFUSED]);
endmodule : bfsp_ctrl

// [hdl/bfsp_map.svh]
// Purpose: offsets, field positions, section boundaries and timing counts of the flash self-program block
// Assumes: word-addressed flash, 125 MHz system clock
// Notes: included by bare name
`ifndef BFSP_MAP_SVH
`define BFSP_MAP_SVH
// ------------------------------------------------------------
// register offsets (word index on the plain port)
// ------------------------------------------------------------
`define BFSP_ADDR_CTRL 4'h0
`define BFSP_ADDR_PTR 4'h1
`define BFSP_ADDR_DATA 4'h2
`define BFSP_ADDR_IRQ_STAT 4'h3
`define BFSP_ADDR_IRQ_MASK 4'h4
`define BFSP_ADDR_STORE 4'h5
`define BFSP_ADDR_LOAD 4'h6
`define BFSP_ADDR_BOUNDS 4'h7
// ------------------------------------------------------------
// control and interrupt field positions
// ------------------------------------------------------------
`define BFSP_CTRL_CMD_EN 0
`define BFSP_CTRL_ERASE 1
`define BFSP_CTRL_WRITE 2
`define BFSP_CTRL_REEN 4
`define BFSP_CTRL_BUSY 6
`define BFSP_IRQ_DONE 0
`define BFSP_IRQ_REFUSED 1
`define BFSP_IRQ_EXPIRED 2
// ------------------------------------------------------------
// section boundaries, geometry and timing
// ------------------------------------------------------------
`define BFSP_NO_READ_WHILE_WRITE_SECTION_START 14'h3800
`define BFSP_BOOT_256 14'h3F00
`define BFSP_BOOT_512 14'h3E00
`define BFSP_BOOT_1K 14'h3C00
`define BFSP_BOOT_2K 14'h3800
`define BFSP_PAGE_WORDS 64
`define BFSP_STORE_WINDOW 3'h4
`define BFSP_PROG_TIME_US 3700
`define BFSP_CLK_MHZ 125
`define BFSP_PROG_CYCLES (`BFSP_PROG_TIME_US * `BFSP_CLK_MHZ)
`endif

// [hdl/bfsp_pkg.sv]
// Purpose: types of the flash self-program block
// Assumes: nothing beyond the map header
// Notes: states and carried structs
package bfsp_pkg;
  typedef enum logic [1:0] {
    BFSP_IDLE = 2'b00,
    BFSP_ARMED = 2'b01,
    BFSP_BUSY = 2'b10
  } bfsp_state_t;
  typedef struct packed {
    logic [7:0] page;
    logic [5:0] word;
    logic byte_sel;
  } bfsp_ptr_t;
  typedef struct packed {
    logic erase;
    logic write;
    logic fill;
    logic [7:0] page;
    logic [5:0] word;
    logic [15:0] data;
  } bfsp_op_t;
endpackage : bfsp_pkg

// [testbench/bfsp_core_model.sv]
// Purpose: behavioural core issuing store and load commands on the register port
// Assumes: one clock; strobes launched by nba right after a rising edge
// Notes: the bench calls its tasks hierarchically
`timescale 1ns/10ps
`include "bfsp_map.svh"
module bfsp_core_model (
  input wire logic CLK_SYS,
  input wire logic EE_BUSY,
  input wire logic [15:0] RDATA,
  output logic [3:0] ADDR,
  output logic [15:0] WDATA,
  output logic WR,
  output logic RD
);
  initial begin
    ADDR = 4'h0;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
  end
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
  // ------------------------------------------------------------
  // timed command: no interrupts exist in this model, so none to mask
  // ------------------------------------------------------------
  task automatic cmd(input logic [15:0] c);
    logic [15:0] s;
    int n;
    n = 0;
    s = 16'h0001;
    while (s[`BFSP_CTRL_CMD_EN] && n < 200) begin
      rd(`BFSP_ADDR_CTRL, s);
      n++;
    end
    while (EE_BUSY === 1'b1 && n < 400) begin
      @(posedge CLK_SYS);
      n++;
    end
    wr(`BFSP_ADDR_CTRL, c);
    wr(`BFSP_ADDR_STORE, 16'h0000);
  endtask : cmd
endmodule : bfsp_core_model

// [testbench/boot_flash_self_program_map_tb.sv]
// Purpose: self-checking bench of the flash self-program block
// Assumes: short program time of 20 cycles
// Notes: one task a scenario
`timescale 1ns/10ps
`include "bfsp_map.svh"
module boot_flash_self_program_map_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic ee = 1'b0;
  logic ce = 1'b1;
  logic [13:0] fa = 14'h0000;
  logic freq = 1'b0;
  logic [3:0] ra;
  logic [15:0] wd, rdat, d, a;
  logic wr, rd, stall, ers, wrt, fill, hb, irq;
  logic [13:0] boot;
  logic [7:0] page;
  logic [5:0] word;
  logic [15:0] fdat;
  int error_cnt = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  bfsp_ctrl #(.PROG_CYCLES(20)) DUT (.CLK_SYS(clk), .NRST(nrst), .CE(ce), .REG_ADDR(ra),
    .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .BOOT_SIZE_FUSE_HI(hi),
    .BOOT_SIZE_FUSE_LO(lo), .EEPROM_WRITE_IN_PROGRESS_FLAG(ee), .FETCH_ADDR(fa), .FETCH_REQ(freq),
    .FETCH_STALL(stall), .BOOT_RESET_ADDR(boot), .FLASH_ERASE(ers), .FLASH_WRITE(wrt),
    .FLASH_FILL(fill), .FLASH_PAGE(page), .FLASH_WORD(word), .FLASH_DATA(fdat),
    .LOAD_HIGH_BYTE(hb), .IRQ(irq));
  bfsp_core_model core (.CLK_SYS(clk), .EE_BUSY(ee), .RDATA(rdat), .ADDR(ra), .WDATA(wd),
    .WR(wr), .RD(rd));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_boot;
    logic [13:0] tb [4];
    tb = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
    for (int i = 0; i < 4; i++) begin
      hi <= i[1];
      lo <= i[0];
      cyc(3);
      chk("boot_addr", {2'b00, tb[i]}, {2'b00, boot});
      core.rd(`BFSP_ADDR_BOUNDS, d);
      chk("bounds", {2'b00, tb[i]}, d);
    end
    $display("test boot done");
  endtask : t_boot
  task automatic t_erase;
    int n;
    core.wr(`BFSP_ADDR_PTR, 16'hEA80);
    core.cmd(16'h0003);
    cyc(1);
    chk("erase", 16'h0001, {15'h0, ers});
    chk("page", 16'h00D5, {8'h00, page});
    core.rd(`BFSP_ADDR_CTRL, d);
    chk("ctrl_busy", 16'h0043, d);
    freq <= 1'b1;
    fa <= 14'h37FF;
    cyc(2);
    chk("stall_rww", 16'h0001, {15'h0, stall});
    fa <= 14'h3800;
    cyc(2);
    chk("stall_no_read_while_write_section", 16'h0000, {15'h0, stall});
    freq <= 1'b0;
    n = 0;
    while (ers !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("erase_end", 16'h0000, {15'h0, ers});
    core.rd(`BFSP_ADDR_CTRL, d);
    chk("ctrl_after", 16'h0040, d);
    core.rd(`BFSP_ADDR_IRQ_STAT, d);
    chk("stat_done", 16'h0001, d);
    core.wr(`BFSP_ADDR_IRQ_MASK, 16'h0007);
    cyc(2);
    a[0] = irq;
    chk("irq_on", 16'h0001, {15'h0, a[0]});
    core.wr(`BFSP_ADDR_IRQ_MASK, 16'h0000);
    cyc(2);
    chk("irq_mask", 16'h0001, {15'h0, a[0] ^ irq});
    core.wr(`BFSP_ADDR_IRQ_MASK, 16'h0007);
    core.wr(`BFSP_ADDR_IRQ_STAT, 16'h0001);
    cyc(2);
    chk("irq_clear", 16'h0000, {15'h0, irq});
    core.cmd(16'h0011);
    cyc(2);
    core.rd(`BFSP_ADDR_CTRL, d);
    chk("ctrl_reen", 16'h0000, d);
    $display("test erase done");
  endtask : t_erase
  task automatic t_fill;
    int n;
    core.wr(`BFSP_ADDR_PTR, 16'h807E);
    core.wr(`BFSP_ADDR_DATA, 16'hA5C3);
    core.cmd(16'h0001);
    n = 0;
    #1;
    while (fill !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    chk("fill", 16'h0001, {15'h0, fill});
    chk("word", 16'h003F, {10'h0, word});
    chk("fdata", 16'hA5C3, fdat);
    cyc(1);
    chk("fill_pulse", 16'h0000, {15'h0, fill});
    core.wr(`BFSP_ADDR_IRQ_STAT, 16'h0007);
    $display("test fill done");
  endtask : t_fill
  task automatic t_write;
    int n;
    core.wr(`BFSP_ADDR_PTR, 16'h3F80);
    core.cmd(16'h0005);
    cyc(1);
    chk("write", 16'h0001, {15'h0, wrt});
    chk("wpage", 16'h007F, {8'h00, page});
    chk("wword", 16'h0000, {10'h0, word});
    n = 0;
    while (wrt !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("write_end", 16'h0000, {15'h0, wrt});
    core.cmd(16'h0011);
    cyc(2);
    core.rd(`BFSP_ADDR_CTRL, d);
    chk("ctrl_wreen", 16'h0000, d);
    core.wr(`BFSP_ADDR_IRQ_STAT, 16'h0007);
    $display("test write done");
  endtask : t_write
  task automatic t_refuse;
    ee <= 1'b1;
    core.wr(`BFSP_ADDR_PTR, 16'h0000);
    core.wr(`BFSP_ADDR_CTRL, 16'h0003);
    core.wr(`BFSP_ADDR_STORE, 16'h0000);
    cyc(2);
    chk("erase_ee", 16'h0000, {15'h0, ers});
    core.rd(`BFSP_ADDR_IRQ_STAT, d);
    chk("stat_ref", 16'h0002, d);
    ee <= 1'b0;
    core.wr(`BFSP_ADDR_IRQ_STAT, 16'h0007);
    core.wr(`BFSP_ADDR_PTR, 16'h0001);
    core.cmd(16'h0003);
    cyc(6);
    chk("erase_odd", 16'h0000, {15'h0, ers});
    core.rd(`BFSP_ADDR_CTRL, d);
    chk("ctrl_exp", 16'h0000, d);
    core.rd(`BFSP_ADDR_IRQ_STAT, d);
    chk("stat_exp", 16'h0004, d);
    core.wr(`BFSP_ADDR_IRQ_STAT, 16'h0007);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_load;
    core.wr(`BFSP_ADDR_PTR, 16'hABCD);
    core.rd(`BFSP_ADDR_LOAD, d);
    chk("load", 16'h15E6, d);
    cyc(1);
    chk("hi_byte", 16'h0001, {15'h0, hb});
    core.rd(4'hF, d);
    chk("unmapped", 16'h0000, d);
    $display("test load done");
  endtask : t_load
  task automatic t_freeze;
    ce <= 1'b0;
    core.wr(`BFSP_ADDR_PTR, 16'h1234);
    ce <= 1'b1;
    core.rd(`BFSP_ADDR_PTR, d);
    chk("ce_freeze", 16'hABCD, d);
    $display("test freeze done");
  endtask : t_freeze
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_boot();
    t_erase();
    t_fill();
    t_write();
    t_refuse();
    t_load();
    t_freeze();
    conclude();
  end
  initial begin
    #(20000 * 8);
    error_cnt++;
    conclude();
  end
endmodule : boot_flash_self_program_map_tb
